// ==== pkg/esa_params.svh ====
// offsets, field positions and counts of the spare/international bit block
// assumes an 8-bit register port with a 9-bit address
`ifndef ESA_PARAMS_SVH
`define ESA_PARAMS_SVH

// ------------------------------------------------------------
// receive side offsets
// ------------------------------------------------------------
`define ESA_OFS_RX_AF 9'h064
`define ESA_OFS_RX_NAF 9'h065
`define ESA_OFS_RX_MF_BASE 9'h066
`define ESA_OFS_SA_CUR 9'h06E
`define ESA_OFS_SA6_CODE 9'h06F
`define ESA_OFS_RX_LATCHED_STATUS_TWO 9'h091
`define ESA_OFS_RX_LATCHED_STATUS_SEVEN 9'h096
`define ESA_OFS_RIM2 9'h0A1
`define ESA_OFS_RX_IRQ_MASK_SEVEN 9'h0A6
`define ESA_OFS_MON_SEL 9'h0A7

// ------------------------------------------------------------
// transmit side offsets
// ------------------------------------------------------------
`define ESA_OFS_TX_SRC 9'h114
`define ESA_OFS_TX_AF 9'h164
`define ESA_OFS_TX_NAF 9'h165
`define ESA_OFS_TX_MF_BASE 9'h166
`define ESA_OFS_TX_LATCHED_STATUS_ONE 9'h190
`define ESA_OFS_TIM1 9'h1A0

// ------------------------------------------------------------
// field positions and counts
// ------------------------------------------------------------
`define ESA_MF_REGS 8
`define ESA_BIT_AF_NEW 0
`define ESA_BIT_MF_NEW 1
`define ESA_BIT_SA_CHG 0
`define ESA_BIT_SA6_CHG 3
`define ESA_BIT_TX_MF 3
`define ESA_SA_LSB 0
`define ESA_SA_MSB 4
`define ESA_SA6_STABLE 3
`define ESA_BYTE_ZERO 8'h00

`endif

// ==== pkg/esa_pkg.sv ====
// types shared by the spare/international bit block
// assumes the params header is compiled alongside
package esa_pkg;

  // eight multiframe bytes: field order makes byte i the i-th register
  typedef struct packed {
    logic [7:0] sa8;
    logic [7:0] sa7;
    logic [7:0] sa6;
    logic [7:0] sa5;
    logic [7:0] sa4;
    logic [7:0] remoteAlarm;
    logic [7:0] intlNonalign;
    logic [7:0] intlAlign;
  } esa_mf_s;

  // register port request
  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
  } esa_bus_s;

  typedef logic [7:0] esa_byte_t;

endpackage : esa_pkg

// ==== rtl/esa_sa6_filter.sv ====
// persistence filter for the received Sa6 codeword
// assumes one submultiframe pulse per received 4-bit nibble
`timescale 1ns/1ps
`default_nettype none
`include "esa_params.svh"

module esa_sa6_filter #(
  parameter int STABLE = `ESA_SA6_STABLE
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic smfPulse,
  input wire logic [3:0] nibble,
  output logic [3:0] code,
  output logic changed
);
  import esa_pkg::*;

  logic [3:0] cand_r;
  logic [1:0] cnt_r;
  logic [3:0] code_r;
  logic chg_r;
  wire same = (nibble == cand_r);
  // saturate so a long stable run cannot wrap and re-fire
  wire [1:0] cntNxt = !same ? 2'h1 : (cnt_r == STABLE[1:0]) ? cnt_r : cnt_r + 2'h1;
  wire update = smfPulse && (cntNxt == STABLE[1:0]) && (nibble != code_r);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cand_r <= 4'h0;
      cnt_r <= 2'h0;
      code_r <= 4'h0;
      chg_r <= 1'b0;
    end
    else
    begin
      if (smfPulse)
      begin
        cand_r <= nibble;
        cnt_r <= cntNxt;
      end
      if (update)
        code_r <= nibble;
      chg_r <= update;
    end
  end

  assign code = code_r;
  assign changed = chg_r;

endmodule : esa_sa6_filter
`default_nettype wire

// ==== rtl/esa_top.sv ====
// spare (Sa) and international (Si) bit access for an E1 framer
// assumes framer strobes are one-cycle pulses on mclk; host uses the plain register port
`timescale 1ns/1ps
`default_nettype none
`include "esa_params.svh"

// Operation
// - in E1 mode capture received align and non-align bytes each align-frame boundary.
// - each such capture sets bit 0 of receive latched status two.
// - eight multiframe receive registers update per CRC-4 multiframe, setting status two bit 1.
// - eight transmit registers; source control selects their insertion into outgoing bits.
// - transmit registers sampled once per multiframe, setting transmit status one bit 3.
// - host updates within 2 ms, else previously held data goes out again.
// - only Sa positions enabled in the monitor select register are watched.
// - change on an enabled Sa position sets bit 0 of status seven.
// - Sa-change raises interrupt only when mask seven bit 0 is set.
// - current received Sa bits readable any time at address 06Eh.
// - Sa6 codeword stored only after three stable submultiframes and when different.
// - stored codeword change sets a flag in status seven, with its own mask.
// - latched flags stay set until a one is written; zero writes leave them.
// - active-low interrupt low while any unmasked latched flag remains set.
module esa_top #(
  parameter int MF_REGS = `ESA_MF_REGS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire esa_pkg::esa_bus_s bus,
  input wire logic e1Mode,
  input wire logic rxAfPulse,
  input wire esa_pkg::esa_byte_t rxAfByte,
  input wire esa_pkg::esa_byte_t rxNafByte,
  input wire logic rxMfPulse,
  input wire esa_pkg::esa_mf_s rxMf,
  input wire logic rxSmfPulse,
  input wire logic [3:0] rxSa6Nibble,
  input wire logic txMfPulse,
  output esa_pkg::esa_byte_t rdData,
  output logic irqN,
  output esa_pkg::esa_mf_s txMf,
  output esa_pkg::esa_byte_t txSrcCtrl,
  output esa_pkg::esa_byte_t txAfByte,
  output esa_pkg::esa_byte_t txNafByte
);
  import esa_pkg::*;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic inMf(input logic [8:0] a, input logic [8:0] base);
    inMf = (a >= base) && (a < base + 9'(MF_REGS));
  endfunction : inMf

  wire wr = bus.wrStrobe;
  wire [8:0] a = bus.addr;
  wire [7:0] wd = bus.wrData;
  wire [2:0] rxIdx = 3'(a - `ESA_OFS_RX_MF_BASE);
  wire [2:0] txIdx = 3'(a - `ESA_OFS_TX_MF_BASE);
  wire wrRls2 = wr && hit(a, `ESA_OFS_RX_LATCHED_STATUS_TWO);
  wire wrRls7 = wr && hit(a, `ESA_OFS_RX_LATCHED_STATUS_SEVEN);
  wire wrTls1 = wr && hit(a, `ESA_OFS_TX_LATCHED_STATUS_ONE);
  wire wrTxMf = wr && inMf(a, `ESA_OFS_TX_MF_BASE);
  wire wrTxSrc = wr && hit(a, `ESA_OFS_TX_SRC);
  wire wrTxAf = wr && hit(a, `ESA_OFS_TX_AF);
  wire wrTxNaf = wr && hit(a, `ESA_OFS_TX_NAF);
  wire wrMonSel = wr && hit(a, `ESA_OFS_MON_SEL);
  wire wrRim2 = wr && hit(a, `ESA_OFS_RIM2);
  wire wrRim7 = wr && hit(a, `ESA_OFS_RX_IRQ_MASK_SEVEN);
  wire wrTim1 = wr && hit(a, `ESA_OFS_TIM1);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  esa_byte_t rxAf_r;
  esa_byte_t rxNaf_r;
  esa_byte_t rxMfReg_r [MF_REGS];
  esa_byte_t txMfReg_r [MF_REGS];
  esa_byte_t txSrc_r;
  esa_byte_t txAf_r;
  esa_byte_t txNaf_r;
  esa_byte_t saCur_r;
  esa_byte_t monSel_r;
  esa_byte_t rx_latched_status_two_r;
  esa_byte_t rx_latched_status_seven_r;
  esa_byte_t tx_latched_status_one_r;
  esa_byte_t rim2_r;
  esa_byte_t rx_irq_mask_seven_r;
  esa_byte_t tim1_r;
  esa_byte_t rdData_r;
  logic irqN_r;
  esa_mf_s txMf_r;
  wire [$bits(esa_mf_s)-1:0] txMfSample;
  logic [3:0] spare6_codeword;
  logic sa6Chg;

  // ------------------------------------------------------------
  // Sa6 codeword filter
  // ------------------------------------------------------------
  esa_sa6_filter #(
    .STABLE(`ESA_SA6_STABLE)
  ) u_sa6 (
    .mclk(mclk),
    .rst_n(rst_n),
    .smfPulse(rxSmfPulse && e1Mode),
    .nibble(rxSa6Nibble),
    .code(spare6_codeword),
    .changed(sa6Chg)
  );

  // ------------------------------------------------------------
  // events
  // ------------------------------------------------------------
  wire afEv = rxAfPulse && e1Mode;
  wire mfEv = rxMfPulse && e1Mode;
  wire [4:0] saNew = rxNafByte[`ESA_SA_MSB:`ESA_SA_LSB];
  wire [4:0] saOld = saCur_r[`ESA_SA_MSB:`ESA_SA_LSB];
  // first capture after reset compares against zero; a set bit then counts as a change
  wire saChgEv = afEv && |((saNew ^ saOld) & monSel_r[`ESA_SA_MSB:`ESA_SA_LSB]);

  wire [7:0] set2 = 8'((afEv ? 8'h01 : 8'h00) << `ESA_BIT_AF_NEW)
                  | 8'((mfEv ? 8'h01 : 8'h00) << `ESA_BIT_MF_NEW);
  wire [7:0] set7 = 8'((saChgEv ? 8'h01 : 8'h00) << `ESA_BIT_SA_CHG)
                  | 8'((sa6Chg ? 8'h01 : 8'h00) << `ESA_BIT_SA6_CHG);
  wire [7:0] setT = 8'((txMfPulse ? 8'h01 : 8'h00) << `ESA_BIT_TX_MF);

  // set beats a same-cycle write-one clear
  wire [7:0] rls2Nxt = (rx_latched_status_two_r & ~(wrRls2 ? wd : `ESA_BYTE_ZERO)) | set2;
  wire [7:0] rls7Nxt = (rx_latched_status_seven_r & ~(wrRls7 ? wd : `ESA_BYTE_ZERO)) | set7;
  wire [7:0] tls1Nxt = (tx_latched_status_one_r & ~(wrTls1 ? wd : `ESA_BYTE_ZERO)) | setT;

  // interrupt from the next flag state so the pin changes on the same edge as the flags
  wire irqAny = |(rls2Nxt & rim2_r) | |(rls7Nxt & rx_irq_mask_seven_r) | |(tls1Nxt & tim1_r);

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  logic [7:0] rdMux;
  always_comb
  begin
    rdMux = `ESA_BYTE_ZERO;
    if (inMf(a, `ESA_OFS_RX_MF_BASE))
      rdMux = rxMfReg_r[rxIdx];
    else if (inMf(a, `ESA_OFS_TX_MF_BASE))
      rdMux = txMfReg_r[txIdx];
    else if (hit(a, `ESA_OFS_RX_AF))
      rdMux = rxAf_r;
    else if (hit(a, `ESA_OFS_RX_NAF))
      rdMux = rxNaf_r;
    else if (hit(a, `ESA_OFS_SA_CUR))
      rdMux = saCur_r;
    else if (hit(a, `ESA_OFS_SA6_CODE))
      rdMux = {4'h0, spare6_codeword};
    else if (hit(a, `ESA_OFS_RX_LATCHED_STATUS_TWO))
      rdMux = rx_latched_status_two_r;
    else if (hit(a, `ESA_OFS_RX_LATCHED_STATUS_SEVEN))
      rdMux = rx_latched_status_seven_r;
    else if (hit(a, `ESA_OFS_TX_LATCHED_STATUS_ONE))
      rdMux = tx_latched_status_one_r;
    else if (hit(a, `ESA_OFS_RIM2))
      rdMux = rim2_r;
    else if (hit(a, `ESA_OFS_RX_IRQ_MASK_SEVEN))
      rdMux = rx_irq_mask_seven_r;
    else if (hit(a, `ESA_OFS_TIM1))
      rdMux = tim1_r;
    else if (hit(a, `ESA_OFS_MON_SEL))
      rdMux = monSel_r;
    else if (hit(a, `ESA_OFS_TX_SRC))
      rdMux = txSrc_r;
    else if (hit(a, `ESA_OFS_TX_AF))
      rdMux = txAf_r;
    else if (hit(a, `ESA_OFS_TX_NAF))
      rdMux = txNaf_r;
  end

  // ------------------------------------------------------------
  // multiframe register arrays
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < MF_REGS; gi++)
    begin : g_mf
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          rxMfReg_r[gi] <= `ESA_BYTE_ZERO;
          txMfReg_r[gi] <= `ESA_BYTE_ZERO;
        end
        else
        begin
          if (mfEv)
            rxMfReg_r[gi] <= rxMf[gi*8 +: 8];
          if (wrTxMf && txIdx == 3'(gi))
            txMfReg_r[gi] <= wd;
        end
      end
      // byte lanes gathered so one process owns the line latch
      assign txMfSample[gi*8 +: 8] = txMfReg_r[gi];
    end
  endgenerate

  // latch for the line only at the multiframe mark; untouched registers resend old data
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      txMf_r <= '0;
    else if (txMfPulse)
      txMf_r <= txMfSample;
  end

  // ------------------------------------------------------------
  // receive captures
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxAf_r <= `ESA_BYTE_ZERO;
      rxNaf_r <= `ESA_BYTE_ZERO;
      saCur_r <= `ESA_BYTE_ZERO;
    end
    else if (afEv)
    begin
      rxAf_r <= rxAfByte;
      rxNaf_r <= rxNafByte;
      saCur_r <= {3'h0, saNew};
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      txSrc_r <= `ESA_BYTE_ZERO;
    else if (wrTxSrc)
      txSrc_r <= wd;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      txAf_r <= `ESA_BYTE_ZERO;
    else if (wrTxAf)
      txAf_r <= wd;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      txNaf_r <= `ESA_BYTE_ZERO;
    else if (wrTxNaf)
      txNaf_r <= wd;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      monSel_r <= `ESA_BYTE_ZERO;
    else if (wrMonSel)
      monSel_r <= wd;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rim2_r <= `ESA_BYTE_ZERO;
    else if (wrRim2)
      rim2_r <= wd;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rx_irq_mask_seven_r <= `ESA_BYTE_ZERO;
    else if (wrRim7)
      rx_irq_mask_seven_r <= wd;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tim1_r <= `ESA_BYTE_ZERO;
    else if (wrTim1)
      tim1_r <= wd;
  end

  // ------------------------------------------------------------
  // status, interrupt and read data
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rx_latched_status_two_r <= `ESA_BYTE_ZERO;
    else
      rx_latched_status_two_r <= rls2Nxt;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rx_latched_status_seven_r <= `ESA_BYTE_ZERO;
    else
      rx_latched_status_seven_r <= rls7Nxt;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tx_latched_status_one_r <= `ESA_BYTE_ZERO;
    else
      tx_latched_status_one_r <= tls1Nxt;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irqN_r <= 1'b1;
    else
      irqN_r <= !irqAny;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdData_r <= `ESA_BYTE_ZERO;
    else
      rdData_r <= bus.rdStrobe ? rdMux : `ESA_BYTE_ZERO;
  end

  assign rdData = rdData_r;
  assign irqN = irqN_r;
  assign txMf = txMf_r;
  assign txSrcCtrl = txSrc_r;
  assign txAfByte = txAf_r;
  assign txNafByte = txNaf_r;

endmodule : esa_top
`default_nettype wire

// ==== verification/esa_framer_model.sv ====
// framer stub: line-side strobes and captured overhead bytes
// assumes the bench calls its tasks between clock edges
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// far-side framer
// ------------------------------------------------------------
module esa_framer_model (
  input wire logic mclk,
  output logic rxAfPulse,
  output esa_pkg::esa_byte_t rxAfByte,
  output esa_pkg::esa_byte_t rxNafByte,
  output logic rxMfPulse,
  output esa_pkg::esa_mf_s rxMf,
  output logic rxSmfPulse,
  output logic [3:0] rxSa6Nibble,
  output logic txMfPulse
);
  import esa_pkg::*;
  initial
  begin
    {rxAfPulse, rxMfPulse, rxSmfPulse, txMfPulse} = 4'h0;
    {rxAfByte, rxNafByte, rxMf, rxSa6Nibble} = '0;
  end
  // data is inverted once the strobe drops, so stale bytes never look valid
  task automatic af(input esa_byte_t a, input esa_byte_t n);
    @(posedge mclk);
    rxAfPulse <= 1'b1;
    rxAfByte <= a;
    rxNafByte <= n;
    @(posedge mclk);
    rxAfPulse <= 1'b0;
    rxAfByte <= ~a;
    rxNafByte <= ~n;
  endtask : af
  task automatic mf(input esa_mf_s m);
    @(posedge mclk);
    rxMfPulse <= 1'b1;
    rxMf <= m;
    @(posedge mclk);
    rxMfPulse <= 1'b0;
    rxMf <= ~m;
  endtask : mf
  task automatic smf(input logic [3:0] n);
    @(posedge mclk);
    rxSmfPulse <= 1'b1;
    rxSa6Nibble <= n;
    @(posedge mclk);
    rxSmfPulse <= 1'b0;
    rxSa6Nibble <= ~n;
  endtask : smf
  task automatic txmf();
    @(posedge mclk);
    txMfPulse <= 1'b1;
    @(posedge mclk);
    txMfPulse <= 1'b0;
  endtask : txmf
endmodule : esa_framer_model
`default_nettype wire

// ==== verification/esa_top_chk.sv ====
// port assertions for the spare-bit access block
// assumes it is bound to esa_top, single clock mclk
`timescale 1ns/1ps
`default_nettype none
`include "esa_params.svh"
module esa_top_chk #(
  parameter int MF_REGS = `ESA_MF_REGS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire esa_pkg::esa_bus_s bus,
  input wire logic e1Mode,
  input wire logic rxAfPulse,
  input wire esa_pkg::esa_byte_t rxAfByte,
  input wire logic rxMfPulse,
  input wire esa_pkg::esa_mf_s rxMf,
  input wire logic rxSmfPulse,
  input wire logic txMfPulse,
  input wire esa_pkg::esa_byte_t rdData,
  input wire logic irqN,
  input wire esa_pkg::esa_mf_s txMf
);
  import esa_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  wire logic afOk;
  wire logic evt;
  wire esa_byte_t mfByte0;
  assign afOk = rxAfPulse & e1Mode;
  assign evt = rxAfPulse | rxMfPulse | rxSmfPulse | txMfPulse | bus.wrStrobe;
  assign mfByte0 = rxMf.intlAlign;
  esa_byte_t lastAf_r;
  esa_byte_t lastMf0_r;
  logic afFlag_r;
  wire logic clrAf;
  assign clrAf = bus.wrStrobe && bus.addr == `ESA_OFS_RX_LATCHED_STATUS_TWO && bus.wrData[`ESA_BIT_AF_NEW];
  // reference of the align capture, first multiframe byte and align flag
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lastAf_r <= 8'h00;
      lastMf0_r <= 8'h00;
      afFlag_r <= 1'b0;
    end
    else
    begin
      if (afOk)
        lastAf_r <= rxAfByte;
      if (rxMfPulse && e1Mode)
        lastMf0_r <= mfByte0;
      afFlag_r <= afOk || (afFlag_r && !clrAf);
    end
  end
  function automatic logic rdAt(input esa_bus_s b, input logic [8:0] a);
    return b.rdStrobe && b.addr == a;
  endfunction : rdAt
  chk_af_capture: assert property (rdAt(bus, `ESA_OFS_RX_AF)
    |=> rdData == $past(lastAf_r)) else $error("align byte not captured");
  chk_af_flag: assert property (rdAt(bus, `ESA_OFS_RX_LATCHED_STATUS_TWO)
    |=> rdData[`ESA_BIT_AF_NEW] == $past(afFlag_r)) else $error("align flag wrong");
  chk_mf_capture: assert property (rdAt(bus, `ESA_OFS_RX_MF_BASE)
    |=> rdData == $past(lastMf0_r)) else $error("multiframe byte not captured");
  chk_rd_idle: assert property (!$past(bus.rdStrobe) |-> rdData == 8'h00)
    else $error("read data outside its cycle");
  chk_unmapped_zero: assert property (rdAt(bus, 9'h1FF) |=> rdData == 8'h00)
    else $error("unmapped read not zero");
  chk_tx_hold: assert property (!$past(txMfPulse) |-> $stable(txMf))
    else $error("tx bytes moved off the multiframe");
  chk_irq_cause: assert property ($fell(irqN) |-> $past(evt) || $past(evt, 2)
    || $past(evt, 3)) else $error("interrupt without cause");
  chk_irq_clear: assert property ($rose(irqN) |-> $past(bus.wrStrobe))
    else $error("interrupt released without a write");
  cover property (afOk);
  cover property (txMfPulse);
  cover property ($fell(irqN));
endmodule : esa_top_chk
`default_nettype wire

// ==== verification/tb_e1_sa_si_bit_access.sv ====
// self-checking bench for the spare-bit access block
// assumes the framer stub supplies every line-side strobe
`timescale 1ns/1ps
`default_nettype none
`include "esa_params.svh"
module tb_e1_sa_si_bit_access;
  import esa_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b1;
  logic e1Mode = 1'b0;
  esa_bus_s bus = '0;
  wire logic rxAfPulse, rxMfPulse, rxSmfPulse, txMfPulse, irqN;
  wire esa_byte_t rxAfByte, rxNafByte, rdData, txSrcCtrl, txAfByte, txNafByte;
  wire esa_mf_s rxMf, txMf;
  wire logic [3:0] rxSa6Nibble;
  int errors = 0;
  int totalChecks = 0;
  int cycles = 0;
  always #12.5 mclk = ~mclk;
  esa_framer_model uFramer (.mclk(mclk), .rxAfPulse(rxAfPulse), .rxAfByte(rxAfByte),
    .rxNafByte(rxNafByte), .rxMfPulse(rxMfPulse), .rxMf(rxMf), .rxSmfPulse(rxSmfPulse),
    .rxSa6Nibble(rxSa6Nibble), .txMfPulse(txMfPulse));
  esa_top DUT (.mclk(mclk), .rst_n(rst_n), .bus(bus), .e1Mode(e1Mode), .rxAfPulse(rxAfPulse),
    .rxAfByte(rxAfByte), .rxNafByte(rxNafByte), .rxMfPulse(rxMfPulse), .rxMf(rxMf),
    .rxSmfPulse(rxSmfPulse), .rxSa6Nibble(rxSa6Nibble), .txMfPulse(txMfPulse),
    .rdData(rdData), .irqN(irqN), .txMf(txMf), .txSrcCtrl(txSrcCtrl), .txAfByte(txAfByte),
    .txNafByte(txNafByte));
  // ------------------------------------------------------------
  // bus and check helpers
  // ------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    totalChecks++;
    if (!ok)
    begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check
  task automatic wr(input logic [8:0] a, input esa_byte_t d);
    @(posedge mclk);
    bus <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
    @(posedge mclk);
    bus.wrStrobe <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [8:0] a, input esa_byte_t e, input string m);
    @(posedge mclk);
    bus <= '{addr: a, wrData: 8'h00, wrStrobe: 1'b0, rdStrobe: 1'b1};
    @(posedge mclk);
    bus.rdStrobe <= 1'b0;
    #1 check(rdData === e, m);
  endtask : rdc
  // ------------------------------------------------------------
  // scenarios: host reads right after each flag
  // ------------------------------------------------------------
  task automatic sAlign();
    uFramer.af(8'h9B, 8'h55);
    rdc(`ESA_OFS_RX_LATCHED_STATUS_TWO, 8'h00, "flag outside E1 mode");
    @(posedge mclk);
    e1Mode <= 1'b1;
    uFramer.af(8'h1B, 8'h5A);
    rdc(`ESA_OFS_RX_AF, 8'h1B, "align byte");
    rdc(`ESA_OFS_RX_NAF, 8'h5A, "non-align byte");
    rdc(`ESA_OFS_SA_CUR, 8'h1A, "current spare bits");
    rdc(`ESA_OFS_RX_LATCHED_STATUS_TWO, 8'h01, "align flag");
    wr(`ESA_OFS_RX_LATCHED_STATUS_TWO, 8'h00);
    rdc(`ESA_OFS_RX_LATCHED_STATUS_TWO, 8'h01, "zero write cleared flag");
    wr(`ESA_OFS_RX_LATCHED_STATUS_TWO, 8'h01);
    rdc(`ESA_OFS_RX_LATCHED_STATUS_TWO, 8'h00, "flag not cleared");
    wr(`ESA_OFS_RX_AF, 8'hFF);
    rdc(`ESA_OFS_RX_AF, 8'h1B, "read-only byte written");
    rdc(9'h1FF, 8'h00, "unmapped read");
  endtask : sAlign
  task automatic sMulti();
    esa_mf_s m;
    m = 64'h8877_6655_4433_2211;
    uFramer.mf(m);
    for (int i = 0; i < 8; i++)
      rdc(`ESA_OFS_RX_MF_BASE + 9'(i), m[8*i +: 8], "multiframe byte");
    rdc(`ESA_OFS_RX_LATCHED_STATUS_TWO, 8'h02, "multiframe flag");
    wr(`ESA_OFS_RX_LATCHED_STATUS_TWO, 8'h02);
  endtask : sMulti
  task automatic sTx();
    for (int i = 0; i < 8; i++)
      wr(`ESA_OFS_TX_MF_BASE + 9'(i), 8'hA0 + 8'(i));
    wr(`ESA_OFS_TX_SRC, 8'h3C);
    #1 check(txSrcCtrl === 8'h3C, "source control");
    check(txMf === 64'h0, "tx bytes before multiframe");
    uFramer.txmf();
    #1 check(txMf === 64'hA7A6_A5A4_A3A2_A1A0, "tx sample");
    rdc(`ESA_OFS_TX_LATCHED_STATUS_ONE, 8'h08, "tx multiframe flag");
    wr(`ESA_OFS_TX_MF_BASE, 8'h5E);
    uFramer.txmf();
    #1 check(txMf === 64'hA7A6_A5A4_A3A2_A15E, "tx resend");
    wr(`ESA_OFS_TIM1, 8'h08);
    @(posedge mclk);
    #1 check(irqN === 1'b0, "tx flag interrupt");
    wr(`ESA_OFS_TX_LATCHED_STATUS_ONE, 8'h08);
    @(posedge mclk);
    #1 check(irqN === 1'b1, "tx flag released");
    wr(`ESA_OFS_TX_AF, 8'h9B);
    wr(`ESA_OFS_TX_NAF, 8'h5F);
    #1 check(txAfByte === 8'h9B && txNafByte === 8'h5F, "tx frame bytes");
  endtask : sTx
  task automatic sSaChange();
    wr(`ESA_OFS_MON_SEL, 8'h01);
    uFramer.af(8'h1B, 8'h18);
    rdc(`ESA_OFS_RX_LATCHED_STATUS_SEVEN, 8'h00, "unselected change flagged");
    uFramer.af(8'h1B, 8'h19);
    rdc(`ESA_OFS_RX_LATCHED_STATUS_SEVEN, 8'h01, "spare change flag");
    check(irqN === 1'b1, "masked interrupt");
    wr(`ESA_OFS_RX_IRQ_MASK_SEVEN, 8'h09);
    @(posedge mclk);
    #1 check(irqN === 1'b0, "unmasked interrupt");
    wr(`ESA_OFS_RX_LATCHED_STATUS_SEVEN, 8'h01);
    @(posedge mclk);
    #1 check(irqN === 1'b1, "interrupt after clear");
  endtask : sSaChange
  task automatic sSa6();
    uFramer.smf(4'h6);
    uFramer.smf(4'h6);
    rdc(`ESA_OFS_SA6_CODE, 8'h00, "codeword too early");
    uFramer.smf(4'h6);
    rdc(`ESA_OFS_SA6_CODE, 8'h06, "codeword");
    rdc(`ESA_OFS_RX_LATCHED_STATUS_SEVEN, 8'h08, "codeword flag");
    check(irqN === 1'b0, "codeword interrupt");
    wr(`ESA_OFS_RX_LATCHED_STATUS_SEVEN, 8'h08);
    for (int i = 0; i < 3; i++)
      uFramer.smf(4'h6);
    rdc(`ESA_OFS_RX_LATCHED_STATUS_SEVEN, 8'h00, "same codeword flagged");
  endtask : sSa6
  task automatic stopTest();
    $display("errors %0d checks %0d", errors, totalChecks);
    if (errors == 0 && totalChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stopTest
  initial
  begin
    // a real falling edge, so the asynchronous reset fires at time zero
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    sAlign();
    sMulti();
    sTx();
    sSaChange();
    sSa6();
    stopTest();
  end
  // whole run needs about 130 cycles
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors++;
      stopTest();
    end
  end
endmodule : tb_e1_sa_si_bit_access
bind esa_top esa_top_chk #(.MF_REGS(MF_REGS)) chk (.mclk(mclk), .rst_n(rst_n), .bus(bus),
  .e1Mode(e1Mode), .rxAfPulse(rxAfPulse), .rxAfByte(rxAfByte), .rxMfPulse(rxMfPulse),
  .rxMf(rxMf), .rxSmfPulse(rxSmfPulse), .txMfPulse(txMfPulse), .rdData(rdData),
  .irqN(irqN), .txMf(txMf));
`default_nettype wire
